/* File: hdl/tgp_pkg.sv */
// Purpose: Shared constants for the two-bit general-purpose I/O port.
// Assumes: Classic Wishbone with 32-bit data, byte addresses.
// Notes: Data and direction registers are eight bits wide in the low byte of each word; mode is three bits.
package tgp_pkg;
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 16;
  localparam int          REG_W         = 8;
  localparam int          NPINS         = 2;
  localparam logic [15:0] ADDR_DATA     = 16'hffda;
  localparam logic [15:0] ADDR_DIR      = 16'hffea;
  localparam logic [15:0] ADDR_MODE     = 16'hfff0;
  localparam logic [7:0]  RST_DATA      = 8'hfc;
  localparam logic [7:0]  RST_DIR       = 8'hfc;
  localparam logic [7:0]  RSV_ONES      = 8'hfc;
  localparam logic [7:0]  ALL_ONES      = 8'hff;
  localparam logic [1:0]  PINS_ZERO     = 2'h0;
  typedef enum logic [2:0] {
    TGP_ACTIVE    = 3'h0,
    TGP_SLEEP     = 3'h1,
    TGP_STANDBY   = 3'h2,
    TGP_WATCH     = 3'h3,
    TGP_SUBACTIVE = 3'h4
  } tgp_mode_type;
  localparam logic [2:0]  RST_MODE      = 3'h0;
endpackage : tgp_pkg

/* File: hdl/tgp_port.sv */
// Purpose: Two-bit GPIO port with direction and data registers on classic Wishbone.
// Assumes: Pin levels are asynchronous and are synchronised here by two flip-flops.
// Notes: Pin outputs carry an active-low enable; pins float in reset and in every mode except active and sleep.

// How it works
// (R1) The port has exactly two pins, each set as input or output on its own.
// (R2) A direction bit of one makes its pin an output and zero makes it an input.
// (R3) Direction bits seven to two are reserved, ignore writes and hold one.
// (R4) The direction register is write-only and every bit of it reads as one.
// (R5) Reset sets the direction register to both pins input with the upper six bits set.
// (R6) A data read of an output pin returns the stored data bit, not the pin level.
// (R7) A data read of an input pin returns the synchronised level of that pin.
// (R8) Data bits seven to two are reserved, read as one and ignore writes.
// (R9) Reset sets the data register with the upper six bits set and both data bits clear.
// (R10) Pins float in reset, keep state in sleep, float in standby, watch and subactive.
// (R11) In active mode an output pin drives its stored data bit from the edge after the write.
module tgp_port #(
  parameter int NPINS = tgp_pkg::NPINS
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [tgp_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [tgp_pkg::DATA_W-1:0] wb_dat_i,
  input  wire logic [3:0]                 wb_sel_i,
  output logic      [tgp_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            wb_err_o,
  input  wire logic [NPINS-1:0]           pin_i,
  output logic      [NPINS-1:0]           pin_o,
  output logic      [NPINS-1:0]           pin_oe_n_o
);

  logic [NPINS-1:0]           sync1_r;
  logic [NPINS-1:0]           sync2_r;
  logic [NPINS-1:0]           dir_r;
  logic [NPINS-1:0]           dir_nxt;
  logic [NPINS-1:0]           dat_r;
  logic [NPINS-1:0]           dat_nxt;
  logic [2:0]                 mode_r;
  logic [2:0]                 mode_nxt;
  logic [NPINS-1:0]           pin_r;
  logic [NPINS-1:0]           pin_nxt;
  logic [NPINS-1:0]           oe_n_r;
  logic [NPINS-1:0]           oe_n_nxt;
  logic                       ack_r;
  logic                       ack_nxt;
  logic                       err_r;
  logic                       err_nxt;
  logic [tgp_pkg::DATA_W-1:0] rdat_r;
  logic [tgp_pkg::DATA_W-1:0] rdat_nxt;
  logic                       req;
  logic                       hit_dat;
  logic                       hit_dir;
  logic                       hit_mode;
  logic [tgp_pkg::REG_W-1:0]  dat_view;

  // Pin levels pass two flip-flops before use.
  always_ff @(posedge clk_i) begin
    sync1_r <= pin_i;
    sync2_r <= sync1_r;
  end

  assign req      = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  assign hit_dat  = wb_adr_i == tgp_pkg::ADDR_DATA;
  assign hit_dir  = wb_adr_i == tgp_pkg::ADDR_DIR;
  assign hit_mode = wb_adr_i == tgp_pkg::ADDR_MODE;

  always_comb begin
    dat_view = tgp_pkg::RSV_ONES; // R8
    for (int i = 0; i < NPINS; i++) begin
      dat_view[i] = dir_r[i] ? dat_r[i] : sync2_r[i]; // R6 R7
    end
  end

  always_comb begin
    dir_nxt  = dir_r;
    dat_nxt  = dat_r;
    mode_nxt = mode_r;
    ack_nxt  = 1'b0;
    err_nxt  = 1'b0;
    rdat_nxt = '0;
    if (req) begin
      ack_nxt = hit_dat || hit_dir || hit_mode;
      err_nxt = !(hit_dat || hit_dir || hit_mode);
      if (wb_we_i && wb_sel_i[0]) begin
        if (hit_dir) begin
          dir_nxt = wb_dat_i[NPINS-1:0]; // R2 R3
        end
        if (hit_dat) begin
          dat_nxt = wb_dat_i[NPINS-1:0]; // R8 R11
        end
        if (hit_mode) begin
          mode_nxt = wb_dat_i[2:0];
        end
      end
      if (!wb_we_i) begin
        if (hit_dir) begin
          rdat_nxt[tgp_pkg::REG_W-1:0] = tgp_pkg::ALL_ONES; // R4
        end
        if (hit_dat) begin
          rdat_nxt[tgp_pkg::REG_W-1:0] = dat_view;
        end
        if (hit_mode) begin
          rdat_nxt[2:0] = mode_r;
        end
      end
    end
    if (rst_i) begin
      dir_nxt  = tgp_pkg::RST_DIR[NPINS-1:0]; // R5
      dat_nxt  = tgp_pkg::RST_DATA[NPINS-1:0]; // R9
      mode_nxt = tgp_pkg::RST_MODE;
      ack_nxt  = 1'b0;
      err_nxt  = 1'b0;
      rdat_nxt = '0;
    end
  end

  always_comb begin
    pin_nxt  = pin_r;
    oe_n_nxt = oe_n_r;
    unique case (tgp_pkg::tgp_mode_type'(mode_r))
      tgp_pkg::TGP_ACTIVE: begin
        pin_nxt  = dat_r; // R11
        oe_n_nxt = ~dir_r; // R1 R2
      end
      tgp_pkg::TGP_SLEEP: begin
        pin_nxt  = pin_r; // R10
        oe_n_nxt = oe_n_r;
      end
      tgp_pkg::TGP_STANDBY, tgp_pkg::TGP_WATCH, tgp_pkg::TGP_SUBACTIVE: begin
        oe_n_nxt = ~tgp_pkg::PINS_ZERO[NPINS-1:0]; // R10
      end
      default: begin
        oe_n_nxt = ~tgp_pkg::PINS_ZERO[NPINS-1:0];
      end
    endcase
    if (rst_i) begin
      pin_nxt  = tgp_pkg::PINS_ZERO[NPINS-1:0];
      oe_n_nxt = ~tgp_pkg::PINS_ZERO[NPINS-1:0]; // R10
    end
  end

  always_ff @(posedge clk_i) begin
    dir_r  <= dir_nxt;
    dat_r  <= dat_nxt;
    mode_r <= mode_nxt;
    ack_r  <= ack_nxt;
    err_r  <= err_nxt;
    rdat_r <= rdat_nxt;
    pin_r  <= pin_nxt;
    oe_n_r <= oe_n_nxt;
  end

  assign wb_dat_o   = rdat_r;
  assign wb_ack_o   = ack_r;
  assign wb_err_o   = err_r;
  assign pin_o      = pin_r;
  assign pin_oe_n_o = oe_n_r;

  sequence s_dat_write;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && hit_dat && !ack_r && !err_r;
  endsequence

  sequence s_dir_write;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && hit_dir && !ack_r && !err_r;
  endsequence

  sequence s_dat_read;
    req && !wb_we_i && hit_dat;
  endsequence

  sequence s_dir_read;
    req && !wb_we_i && hit_dir;
  endsequence

  sequence s_plain_read;
    req && !wb_we_i;
  endsequence

  sequence s_unmapped;
    req && !(hit_dat || hit_dir || hit_mode);
  endsequence

  a_dir_reads_ones: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (req && !wb_we_i && hit_dir) |=> (wb_dat_o[7:0] == 8'hff && wb_ack_o))
    else $error("direction read not all ones");

  a_data_rsv_ones: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (req && !wb_we_i && hit_dat) |=> (wb_dat_o[7:2] == 6'h3f))
    else $error("data reserved bits not one");

  a_out_read_stored: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (req && !wb_we_i && hit_dat && dir_r[0]) |=> (wb_dat_o[0] == $past(dat_r[0])))
    else $error("output pin read not stored value");

  a_in_read_pin: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (req && !wb_we_i && hit_dat && !dir_r[1]) |=> (wb_dat_o[1] == $past(sync2_r[1])))
    else $error("input pin read not pin level");

  a_reset_values: assert property (@(posedge clk_i) // R5
    rst_i |=> (dir_r == 2'h0 && dat_r == 2'h0 && oe_n_r == 2'h3))
    else $error("reset values wrong");

  a_out_drives: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (s_dat_write ##1 (mode_r == 3'h0)) |=> (pin_o == $past(dat_r)))
    else $error("pin does not follow data write");

  a_dir_enables: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (s_dir_write ##1 (mode_r == 3'h0)) |=> (pin_oe_n_o == ~$past(dir_r)))
    else $error("enable does not follow direction");

  a_standby_float: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (mode_r == 3'h2 || mode_r == 3'h3 || mode_r == 3'h4) |=> (pin_oe_n_o == 2'h3))
    else $error("pins not floating in low power");

  a_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (mode_r == 3'h1 && $past(mode_r) == 3'h1) |=> $stable(pin_o) && $stable(pin_oe_n_o))
    else $error("pins changed in sleep");

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // Checks on register access.
  a_dir_write_lands: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    s_dir_write |=> (dir_r == $past(wb_dat_i[NPINS-1:0])))
    else $error("direction write not stored");

  a_dat_write_lands: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    s_dat_write |=> (dat_r == $past(wb_dat_i[NPINS-1:0])))
    else $error("data write not stored");

  a_masked_write: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (req && wb_we_i && !wb_sel_i[0]) |=> ($stable(dir_r) && $stable(dat_r) && $stable(mode_r)))
    else $error("masked write changed a register");

  a_read_no_change: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    s_plain_read |=> ($stable(dir_r) && $stable(dat_r)))
    else $error("read changed a register");

  a_dat_read_ack: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    s_dat_read |=> (wb_ack_o && !wb_err_o))
    else $error("data read not acknowledged");

  a_dir_read_ack: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    s_dir_read |=> (wb_ack_o && !wb_err_o))
    else $error("direction read not acknowledged");

  a_upper_lanes_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    wb_ack_o |-> (wb_dat_o[tgp_pkg::DATA_W-1:tgp_pkg::REG_W] == '0))
    else $error("upper read lanes not zero");

  a_out_read_hi: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (req && !wb_we_i && hit_dat && dir_r[1]) |=> (wb_dat_o[1] == $past(dat_r[1])))
    else $error("upper output pin read not stored value");

  a_in_read_lo: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (req && !wb_we_i && hit_dat && !dir_r[0]) |=> (wb_dat_o[0] == $past(sync2_r[0])))
    else $error("lower input pin read not pin level");

  a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    s_unmapped |=> (wb_err_o && !wb_ack_o && $stable(dir_r) && $stable(dat_r)))
    else $error("unmapped access not refused");

  a_err_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    wb_err_o |=> !wb_err_o)
    else $error("error longer than one cycle");

  a_no_double_answer: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    !(wb_ack_o && wb_err_o))
    else $error("ack and error together");

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    !(wb_cyc_i && wb_stb_i) |=> (!wb_ack_o && !wb_err_o))
    else $error("answer without request");

  // Checks on pin behaviour.
  a_sync_depth: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    sync2_r == $past(pin_i, 2))
    else $error("pin level not two stages late");

  a_reset_float: assert property (@(posedge clk_i) // R10
    rst_i |=> (pin_oe_n_o == '1 && pin_o == '0))
    else $error("pins not floating in reset");

  a_active_drive: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (mode_r == 3'h0) |=> (pin_o == $past(dat_r)))
    else $error("active pin not driving data");

  a_active_enable: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (mode_r == 3'h0) |=> (pin_oe_n_o == ~$past(dir_r)))
    else $error("active enable not following direction");

  a_input_floats: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (mode_r == 3'h0 && !dir_r[0]) |=> pin_oe_n_o[0])
    else $error("input pin driven");

  a_spare_modes_float: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (mode_r > 3'h4) |=> (pin_oe_n_o == '1))
    else $error("pins not floating in spare mode");

endmodule // tgp_port

/* File: dv/tb_tgp_port.sv */
// Purpose: Self-checking bench for the two-bit port over classic Wishbone.
// Assumes: Answers come within a few cycles; pin levels pass two sync stages.
// Notes: Compares are counted and a watchdog ends a hung run.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_tgp_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  sel_v = 4'h1;
  logic        wb_ack_o, wb_err_o, er;
  logic [1:0]  pin_i = 2'h0, pin_o, pin_oe_n_o;
  int          mismatches = 0;
  int          n_compared = 0;
  always #50 clk_i = ~clk_i;
  tgp_port uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= sel_v;
    do begin
      @(posedge clk_i);
    end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    rd = wb_dat_o;
    er = wb_err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    `CHK(pin_oe_n_o, 2'h3)
    rst_i <= 1'b0;
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hfc)
    bus(1'b0, tgp_pkg::ADDR_DIR, 8'h0);
    `CHK(rd, 32'hff)
    bus(1'b1, tgp_pkg::ADDR_DIR, 8'hff);
    bus(1'b0, tgp_pkg::ADDR_DIR, 8'h0);
    `CHK(rd, 32'hff)
    settle();
    `CHK(pin_oe_n_o, 2'h0)
    pin_i <= 2'h2;
    bus(1'b1, tgp_pkg::ADDR_DATA, 8'h01);
    settle();
    `CHK(pin_o, 2'h1)
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hfd)
    bus(1'b1, tgp_pkg::ADDR_DIR, 8'h01);
    settle();
    `CHK(pin_oe_n_o, 2'h2)
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hff)
    pin_i <= 2'h0;
    settle();
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hfd)
    bus(1'b1, tgp_pkg::ADDR_DATA, 8'h02);
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hfc)
    bus(1'b1, tgp_pkg::ADDR_DIR, 8'h03);
    bus(1'b1, tgp_pkg::ADDR_DATA, 8'h03);
    bus(1'b1, tgp_pkg::ADDR_MODE, 8'h01);
    bus(1'b1, tgp_pkg::ADDR_DATA, 8'h00);
    settle();
    `CHK({pin_oe_n_o, pin_o}, 4'h3)
    for (int m = 2; m <= 5; m++) begin
      bus(1'b1, tgp_pkg::ADDR_MODE, m[7:0]);
      settle();
      `CHK(pin_oe_n_o, 2'h3)
    end
    bus(1'b1, tgp_pkg::ADDR_MODE, 8'h00);
    settle();
    `CHK({pin_oe_n_o, pin_o}, 4'h0)
    sel_v = 4'h0;
    bus(1'b1, tgp_pkg::ADDR_DATA, 8'h03);
    sel_v = 4'h1;
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hfc)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(pin_oe_n_o, 2'h3)
    rst_i <= 1'b0;
    bus(1'b0, tgp_pkg::ADDR_DATA, 8'h0);
    `CHK(rd, 32'hfc)
    settle();
    `CHK(pin_oe_n_o, 2'h3)
    bus(1'b0, 16'hff00, 8'h0);
    `CHK(er, 1'b1)
    settle();
    complete_run();
  end
endmodule // tb_tgp_port
